// >>> rtl/hmw_pkg.sv
// Purpose: Constants for the host MAC wake-up control block
// Assumes: APB with 32-bit data, register indices times four give byte addresses
// Notes:   Offsets are word indices
package hmw_pkg;
    // ==========================================================
    // Register map
    localparam int unsigned HMW_ADDR_W           = 8;
    localparam int unsigned HMW_IDX_FILTER       = 32'h0000_000b;
    localparam int unsigned HMW_IDX_WAKE_CSR     = 32'h0000_000c;
    localparam int unsigned HMW_IDX_IRQ_MASK     = 32'h0000_0010;
    localparam int unsigned HMW_IDX_FILTER_PTR   = 32'h0000_0011;
    localparam int unsigned HMW_IDX_POWER        = 32'h0000_0012;
    localparam logic [HMW_ADDR_W-1:0] HMW_ADDR_FILTER     = 8'h2c;
    localparam logic [HMW_ADDR_W-1:0] HMW_ADDR_WAKE_CSR   = 8'h30;
    localparam logic [HMW_ADDR_W-1:0] HMW_ADDR_IRQ_MASK   = 8'h40;
    localparam logic [HMW_ADDR_W-1:0] HMW_ADDR_FILTER_PTR = 8'h44;
    localparam logic [HMW_ADDR_W-1:0] HMW_ADDR_POWER      = 8'h48;
    // ==========================================================
    // Wake-up control and status fields
    localparam int unsigned HMW_BIT_MAGIC_EN     = 1;
    localparam int unsigned HMW_BIT_REMOTE_EN    = 2;
    localparam int unsigned HMW_BIT_MAGIC_SEEN   = 5;
    localparam int unsigned HMW_BIT_REMOTE_SEEN  = 6;
    localparam int unsigned HMW_BIT_UNICAST_EN   = 9;
    localparam logic [31:0] HMW_CSR_RW_MASK      = 32'h0000_0206;
    localparam logic [31:0] HMW_CSR_W1C_MASK     = 32'h0000_0060;
    // Interrupt status bits: 0 magic, 1 remote, 2 unicast, 3 wake
    localparam int unsigned HMW_IRQ_W            = 4;
    localparam int unsigned HMW_IRQ_UNICAST      = 2;
    localparam int unsigned HMW_IRQ_WAKE         = 3;
    localparam int unsigned HMW_DA_GROUP_BIT     = 0;
    // ==========================================================
    // Filter storage
    localparam int unsigned HMW_FILTER_WORDS     = 8;
    localparam int unsigned HMW_FILTER_PTR_W     = 3;
    localparam logic [31:0] HMW_ZERO             = 32'h0000_0000;
endpackage

// >>> rtl/hmw_wakeup_control.sv
// Purpose: Wake-up control, status flags and filter word storage of the host MAC
// Assumes: Frame classifier delivers one-cycle result strobes per received frame
// Notes:   Filter words are write-only on the bus; matching is done by the classifier
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [RL1] Unicast enable lets any global unicast frame wake the MAC from power saving; the code wakes only on good frames.
// [RL2] A frame is global unicast when destination address bit 0 is zero.
// [RL3] A valid filter-matched remote wake-up frame sets the remote seen flag.
// [RL4] A valid magic packet sets the magic packet seen flag.
// [RL5] Remote wake enable arms wake-up frame detection using the stored filter.
// [RL6] Magic enable arms magic wake; when clear, a magic packet wakes only through the unicast or remote path.
// [RL7] Control register plus filter words form the full wake-up configuration.
// [RL8] Filter writes load consecutive words from the first, wrapping after eight.
// [RL9] Enables and flags reset to zero, reserved bits read zero, flags sticky.
module hmw_wakeup_control
    import hmw_pkg::*;
#(
    parameter int unsigned FILTER_WORDS = hmw_pkg::HMW_FILTER_WORDS
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_arst_n,
    input  wire logic                          i_psel,
    input  wire logic                          i_penable,
    input  wire logic                          i_pwrite,
    input  wire logic [hmw_pkg::HMW_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]                   i_pwdata,
    output logic      [31:0]                   o_prdata,
    output logic                               o_pready,
    output logic                               o_pslverr,
    input  wire logic                          i_frame_valid,
    input  wire logic                          i_frame_good,
    input  wire logic [7:0]                    i_frame_da_byte0,
    input  wire logic                          i_frame_magic,
    input  wire logic                          i_frame_filter_hit,
    input  wire logic                          i_sleep_req,
    output logic                               o_power_save,
    output logic                               o_wake_event,
    output logic [31:0]                        o_filter_word,
    output logic                               o_irq
);
    import hmw_pkg::*;

    initial begin
        if (FILTER_WORDS != (1 << HMW_FILTER_PTR_W)) begin
            $error("FILTER_WORDS must match the filter pointer width");
        end
    end

    // ==========================================================
    // State
    logic [31:0]                 ctrl_q, ctrl_d;
    logic [HMW_IRQ_W-1:0]        irq_st_q, irq_st_d;
    logic [HMW_IRQ_W-1:0]        irq_mask_q, irq_mask_d;
    logic [HMW_FILTER_PTR_W-1:0] fptr_q, fptr_d;
    logic [31:0]                 filt_q [FILTER_WORDS];
    logic [31:0]                 rdata_q, rdata_d;
    logic                        ready_q, ready_d;
    logic                        err_q, err_d;
    logic                        psave_q, psave_d;
    logic                        wake_q, wake_d;
    logic [31:0]                 fword_q, fword_d;
    logic                        irq_q, irq_d;

    logic                        wr_acc;
    logic                        rd_acc;
    logic                        hit_csr, hit_filt, hit_mask, hit_ptr, hit_pwr, hit_any;
    logic                        ev_magic, ev_remote, ev_unicast, ev_wake;
    logic [HMW_IRQ_W-1:0]        ev_vec;

    // ==========================================================
    // Bus decode; access phase with one wait state, answered by a registered ready
    assign wr_acc   = i_psel && i_penable && i_pwrite && !ready_q;
    assign rd_acc   = i_psel && i_penable && !i_pwrite && !ready_q;
    assign hit_csr  = (i_paddr == HMW_ADDR_WAKE_CSR);
    assign hit_filt = (i_paddr == HMW_ADDR_FILTER);
    assign hit_mask = (i_paddr == HMW_ADDR_IRQ_MASK);
    assign hit_ptr  = (i_paddr == HMW_ADDR_FILTER_PTR);
    assign hit_pwr  = (i_paddr == HMW_ADDR_POWER);
    assign hit_any  = hit_csr || hit_filt || hit_mask || hit_ptr || hit_pwr;

    // ==========================================================
    // Frame classification
    // Only good frames count; a frame with a bad check sequence is not valid
    assign ev_magic   = i_frame_valid && i_frame_good && i_frame_magic
                        && ctrl_q[HMW_BIT_MAGIC_EN];                          // [RL4] [RL6]
    assign ev_remote  = i_frame_valid && i_frame_good && i_frame_filter_hit
                        && ctrl_q[HMW_BIT_REMOTE_EN];                         // [RL3] [RL5] [RL7]
    assign ev_unicast = i_frame_valid && i_frame_good
                        && !i_frame_da_byte0[HMW_DA_GROUP_BIT]                // [RL2]
                        && ctrl_q[HMW_BIT_UNICAST_EN];                        // [RL1]
    assign ev_wake    = psave_q && (ev_magic || ev_remote || ev_unicast);     // [RL1] [RL6]
    assign ev_vec     = {ev_wake, ev_unicast, ev_remote, ev_magic};

    // ==========================================================
    // Next state
    always_comb begin
        ctrl_d     = ctrl_q;
        irq_st_d   = irq_st_q;
        irq_mask_d = irq_mask_q;
        fptr_d     = fptr_q;
        rdata_d    = HMW_ZERO;
        ready_d    = 1'b0;
        err_d      = 1'b0;
        psave_d    = psave_q;
        wake_d     = ev_wake;
        fword_d    = filt_q[fptr_q];
        if (i_psel && i_penable && !ready_q) begin
            ready_d = 1'b1;
            err_d   = !hit_any;
        end
        if (wr_acc && hit_csr) begin
            // Reserved bits ignore writes, seen flags clear on one
            ctrl_d = (ctrl_q & ~HMW_CSR_RW_MASK) | (i_pwdata & HMW_CSR_RW_MASK);  // [RL9]
            ctrl_d = ctrl_d & ~(i_pwdata & HMW_CSR_W1C_MASK);                    // [RL9]
        end
        if (wr_acc && hit_filt) begin
            fptr_d = fptr_q + 1'b1;                                              // [RL8]
        end
        if (wr_acc && hit_mask) begin
            irq_mask_d = i_pwdata[HMW_IRQ_W-1:0];
        end
        if (wr_acc && hit_ptr) begin
            irq_st_d = irq_st_q & ~i_pwdata[HMW_IRQ_W-1:0];
        end
        if (wr_acc && hit_pwr) begin
            psave_d = i_pwdata[0];
        end
        // Seen flags and interrupt status: set wins over a clear in the same cycle; a wake clears power save over a sleep request
        if (ev_magic) begin
            ctrl_d[HMW_BIT_MAGIC_SEEN] = 1'b1;                                   // [RL4]
        end
        if (ev_remote) begin
            ctrl_d[HMW_BIT_REMOTE_SEEN] = 1'b1;                                  // [RL3]
        end
        irq_st_d = irq_st_d | ev_vec;
        if (i_sleep_req) begin
            psave_d = 1'b1;
        end
        if (ev_wake) begin
            psave_d = 1'b0;                                                      // [RL1]
        end
        if (rd_acc) begin
            if (hit_csr) begin
                rdata_d = ctrl_q & (HMW_CSR_RW_MASK | HMW_CSR_W1C_MASK);         // [RL9]
            end else if (hit_mask) begin
                rdata_d = {{(32-HMW_IRQ_W){1'b0}}, irq_mask_q};
            end else if (hit_ptr) begin
                rdata_d = {{(32-HMW_IRQ_W){1'b0}}, irq_st_q};
            end else if (hit_pwr) begin
                // Pointer sits above the power bit so software can see where the next word lands
                rdata_d = {{(31-HMW_FILTER_PTR_W){1'b0}}, fptr_q, psave_q};
            end else begin
                // Filter words are write-only and read as zero
                rdata_d = HMW_ZERO;
            end
        end
        irq_d = |(irq_st_d & irq_mask_d);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q     <= HMW_ZERO;                                              // [RL9]
            irq_st_q   <= '0;
            irq_mask_q <= '0;
            fptr_q     <= '0;                                                    // [RL8]
            rdata_q    <= HMW_ZERO;
            ready_q    <= 1'b0;
            err_q      <= 1'b0;
            psave_q    <= 1'b0;
            wake_q     <= 1'b0;
            fword_q    <= HMW_ZERO;
            irq_q      <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            irq_st_q   <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            fptr_q     <= fptr_d;
            rdata_q    <= rdata_d;
            ready_q    <= ready_d;
            err_q      <= err_d;
            psave_q    <= psave_d;
            wake_q     <= wake_d;
            fword_q    <= fword_d;
            irq_q      <= irq_d;
        end
    end

    // Filter words hold no reset; software loads all eight before use
    always_ff @(posedge i_mclk) begin
        if (wr_acc && hit_filt) begin
            filt_q[fptr_q] <= i_pwdata;                                          // [RL8] [RL7]
        end
    end

    assign o_prdata     = rdata_q;
    assign o_pready     = ready_q;
    assign o_pslverr    = err_q;
    assign o_power_save = psave_q;
    assign o_wake_event = wake_q;
    assign o_filter_word = fword_q;
    assign o_irq        = irq_q;
endmodule

`default_nettype wire

// >>> verification/hmw_frame_src.sv
// Purpose: Fabric model giving one frame result per call
// Assumes: Same clock as the block
// Notes:   Idle fields are inverted so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module hmw_frame_src (
    input  wire logic       i_mclk,
    output logic            o_valid, o_good, o_magic, o_hit,
    output logic      [7:0] o_da0
);
    initial {o_valid, o_good, o_magic, o_hit, o_da0} = '0;
    task automatic send(input logic g, input logic [7:0] d, input logic m, input logic h);
        @(posedge i_mclk);
        {o_valid, o_good, o_magic, o_hit, o_da0} <= {1'b1, g, m, h, d};
        @(posedge i_mclk);
        {o_valid, o_good, o_magic, o_hit, o_da0} <= {1'b0, ~g, ~m, ~h, ~d};
    endtask
endmodule
`default_nettype wire

// >>> verification/hmw_wakeup_control_checker.sv
// Purpose: Port checks for the wake-up control block
// Assumes: Bound to the top module
// Notes:   One wait state per access
`timescale 1ns/100ps
`default_nettype none
module hmw_wakeup_control_checker
    import hmw_pkg::*;
(
    input wire logic i_mclk, i_arst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
    input wire logic [hmw_pkg::HMW_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic i_frame_valid, i_frame_good, o_power_save, o_wake_event
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // ==========================================
    // Bus answer and wake timing
    wait_state_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("access not answered");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
    error_ready_a: assert property (o_pslverr |-> o_pready) else $error("stray error");
    error_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == '0)
        else $error("refused read not zero");
    csr_reserved_a:
        assert property (o_pready && !i_pwrite && i_paddr == HMW_ADDR_WAKE_CSR
        |-> (o_prdata & 32'hFFFF_FD99) == '0) else $error("reserved bits set");
    wake_sleep_a:
        assert property (o_wake_event |-> $past(o_power_save) && !o_power_save)
        else $error("wake outside power saving");
    wake_cause_a:
        assert property (o_wake_event |-> $past(i_frame_valid) && $past(i_frame_good))
        else $error("wake without good frame");
    wake_pulse_a: assert property (o_wake_event |=> !o_wake_event) else $error("wake held");
endmodule
bind hmw_wakeup_control hmw_wakeup_control_checker u_chk (.i_mclk(i_mclk),
    .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .i_frame_valid(i_frame_valid), .i_frame_good(i_frame_good),
    .o_power_save(o_power_save), .o_wake_event(o_wake_event));
`default_nettype wire

// >>> verification/hmw_wakeup_control_tb.sv
// Purpose: Self-checking bench for the wake-up control block
// Assumes: Fabric model drives frame results
// Notes:   No enable and each single enable swept against every frame result while power saving
`timescale 1ns/100ps
`default_nettype none
module hmw_wakeup_control_tb;
    import hmw_pkg::*;
    logic        clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0;
    logic [7:0]  adr = '0, fd;
    logic [31:0] wd = '0, prd, fw, rd, e;
    logic        rdy, perr, err, ps, wake, irq, fv, fg, fm, fh, ms, rs, x;
    int          n_errors = 0, comparisons = 0, i;
    hmw_wakeup_control dut (.i_mclk(clk), .i_arst_n(rst_n), .i_psel(sel), .i_penable(en),
        .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(perr), .i_frame_valid(fv), .i_frame_good(fg), .i_frame_da_byte0(fd),
        .i_frame_magic(fm), .i_frame_filter_hit(fh), .i_sleep_req(1'b0),
        .o_power_save(ps), .o_wake_event(wake), .o_filter_word(fw), .o_irq(irq));
    hmw_frame_src src (.i_mclk(clk), .o_valid(fv), .o_good(fg), .o_magic(fm),
        .o_hit(fh), .o_da0(fd));
    always #2 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {sel, en, wr, adr, wd} <= {2'b10, w, a, d};
        @(posedge clk);
        en <= 1'b1;
        // Wait for the answer however long it takes; only the watchdog ends a hang
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        {err, rd} = {perr, prd};
        {sel, en} <= 2'b00;
    endtask
    task automatic chk(input string s, input logic [31:0] v, input logic [31:0] g);
        comparisons++;
        if (g !== v) n_errors++;
        if (g !== v) $display("CHECK FAILED %s expected %h seen %h", s, v, g);
    endtask
    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, '0);
        chk(s, v, rd);
    endtask
    task automatic stop_test(input int extra);
        n_errors += extra;
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial #20000 stop_test(1);
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc("csr", HMW_ADDR_WAKE_CSR, '0);
        apb(1'b1, HMW_ADDR_WAKE_CSR, 32'hFFFF_FFFF);
        rdc("csr", HMW_ADDR_WAKE_CSR, 32'h0000_0206);
        rdc("unmapped", 8'h08, '0);
        chk("slverr", 1, err);
        apb(1'b1, HMW_ADDR_IRQ_MASK, 32'h0000_000F);
        for (i = 0; i < 64; i++) begin
            e = {22'h0, i[5] & i[4], 6'h00, i[5] & !i[4], !i[5] & i[4], 1'b0};
            ms = i[3] & i[1] & e[1];
            rs = i[3] & i[0] & e[2];
            x = ms | rs | (i[3] & !i[2] & e[9]);
            apb(1'b1, HMW_ADDR_WAKE_CSR, e | 32'h0000_0060);
            apb(1'b1, 8'h44, 32'h0000_000F);
            apb(1'b1, HMW_ADDR_POWER, 32'h0000_0001);
            src.send(i[3], {7'h55, i[2]}, i[1], i[0]);
            #1 chk("wake", x, wake);
            chk("power save", !x, ps);
            chk("irq", x, irq);
            rdc("csr", HMW_ADDR_WAKE_CSR, e | {rs, ms, 5'h00});
            apb(1'b1, HMW_ADDR_POWER, '0);
        end
        for (i = 0; i < 9; i++) apb(1'b1, HMW_ADDR_FILTER, 32'hA5A5_0000 + i);
        #1 chk("filter word", 32'hA5A5_0001, fw);
        apb(1'b1, HMW_ADDR_IRQ_MASK, '0);
        apb(1'b1, HMW_ADDR_POWER, 32'h0000_0001);
        src.send(1'b1, 8'h00, 1'b0, 1'b0);
        #1 chk("masked irq", 0, irq);
        stop_test(0);
    end
endmodule
`default_nettype wire
